// ---- cas_consts.svh ----
// constants of the cell acquisition sequencer
// Behaviour
// - each conversion yields one 12-bit ALU value
// - two scans averaged into 14-bit measurement
// - aux converted once, stored 12-bit
// - oversampling averages consecutive measurement cycles
// - cells measured when enable bits 11:0 set
// - result left-justified, bits 1:0 zero
// - disabled channel reads all zeros
// - polarity bit selects bipolar or unipolar coding
// - diagnostic modes force their own coding
// - enable bit 14 measures block voltage
// - divider connected only while bit 15 set
// - enable bits 13:12 select aux inputs
// - bias modes 00/01 follow the acquisition
// - bias mode 10 on, 11 off
// - aux channels converted last
// - aux settle 6us plus field times 6us
// - twelve calibration words, checksum in id bits 15:8
`ifndef CAS_CONSTS_SVH
`define CAS_CONSTS_SVH
`define CAS_ADDR_CHANNEL_ENABLE  6'h00
`define CAS_ADDR_ACQ_CONFIG      6'h01
`define CAS_ADDR_SCAN_CTRL       6'h02
`define CAS_ADDR_CELL_BASE       6'h10
`define CAS_ADDR_BLOCK           6'h1C
`define CAS_ADDR_AUX_ONE         6'h1D
`define CAS_ADDR_AUX_TWO         6'h1E
`define CAS_ADDR_ID_TWO          6'h1F
`define CAS_ADDR_CAL_BASE        6'h20
`define CAS_BIT_BLOCK_MEAS       14
`define CAS_BIT_BLOCK_CONNECT    15
`define CAS_BIT_AUX_ONE          12
`define CAS_BIT_AUX_TWO          13
`define CAS_BIT_POLARITY         10
`define CAS_BIT_DIAG_FORCE       11
`define CAS_BIT_DIAG_BIPOLAR     12
`define CAS_BIT_SCAN_START       0
`define CAS_BIT_SCAN_DONE        1
`define CAS_BIT_BUSY             2
`define CAS_RESET_WORD           16'h0000
`define CAS_STEP_NS              6000
`define CAS_CLK_NS               100
`define CAS_STEP_CYCLES          ((`CAS_STEP_NS + `CAS_CLK_NS - 1) / `CAS_CLK_NS)
`define CAS_BIPOLAR_OFFSET       15'h0800
`endif

// ---- cas_pkg.sv ----
// types of the cell acquisition sequencer
package cas_pkg;
    typedef enum logic [2:0] {
        CAS_IDLE,
        CAS_PICK,
        CAS_REQ,
        CAS_WAIT,
        CAS_SETTLE,
        CAS_STORE,
        CAS_FINISH
    } cas_state_t;
endpackage : cas_pkg

// ---- cas_sequencer.sv ----
// acquisition sequencer, averaging and result registers
//
// Our own choices: the placing of the registers and strobed register access.
`include "cas_consts.svh"
module cas_sequencer #(
    parameter int          OVS_CYCLES = 1,
    parameter logic [15:0] CAL_INIT   = 16'h0000,
    parameter logic [7:0]  CAL_CRC    = 8'h00
) (
    // clock and reset
    input  wire logic        sys_clk,
    input  wire logic        rst,
    // register port
    input  wire logic [5:0]  reg_addr,
    input  wire logic [15:0] reg_wdata,
    input  wire logic        reg_wr,
    input  wire logic        reg_rd,
    output logic      [15:0] reg_rdata,
    // adc and multiplexer
    output logic      [3:0]  mux_select,
    output logic             mux_invert,
    output logic             adc_start,
    input  wire logic        adc_done,
    input  wire logic [11:0] adc_data,
    // analog controls
    output logic             block_divider_connect,
    output logic             thermistor_bias_output,
    output logic             use_bias_reference,
    output logic             scan_done
);
    // channel 0..11 cells, 12 block, 13 aux one, 14 aux two
    if (OVS_CYCLES < 1 || OVS_CYCLES > 128) begin : g_bad_ovs
        $error("cas_sequencer: OVS_CYCLES out of range");
    end

    localparam int STEPS = `CAS_STEP_CYCLES;

    logic [15:0] channel_enable_reg;
    logic [15:0] acquisition_config_reg;
    logic [15:0] result_reg [0:14];
    logic [22:0] accum_reg  [0:12];
    logic        scan_done_reg;
    logic        busy_reg;
    logic [15:0] rdata_reg;
    cas_pkg::cas_state_t state_reg;
    logic [3:0]  chan_reg;
    logic        pass_reg;
    logic [7:0]  ovs_reg;
    logic [6:0]  step_reg;
    logic [15:0] tick_reg;
    logic        adc_done_s1;
    logic        adc_done_s2;
    logic [11:0] adc_data_s1;
    logic [11:0] adc_data_s2;
    logic        start_hit;
    logic        en_now;
    logic [5:0]  aux_steps;
    logic        bipolar;

    assign start_hit = reg_wr && reg_addr == `CAS_ADDR_SCAN_CTRL && reg_wdata[`CAS_BIT_SCAN_START];
    assign en_now    = (chan_reg < 4'd12) ? channel_enable_reg[chan_reg] :
                       (chan_reg == 4'd12) ? channel_enable_reg[`CAS_BIT_BLOCK_MEAS] :
                       (chan_reg == 4'd13) ? channel_enable_reg[`CAS_BIT_AUX_ONE] :
                       channel_enable_reg[`CAS_BIT_AUX_TWO];
    assign aux_steps = acquisition_config_reg[5:0];
    assign bipolar   = acquisition_config_reg[`CAS_BIT_DIAG_FORCE] ?
                       acquisition_config_reg[`CAS_BIT_DIAG_BIPOLAR] :
                       acquisition_config_reg[`CAS_BIT_POLARITY];

    // adc handshake crosses from the analog domain
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            adc_done_s1 <= 1'b0;
            adc_done_s2 <= 1'b0;
            adc_data_s1 <= 12'h000;
            adc_data_s2 <= 12'h000;
        end else begin
            adc_done_s1 <= adc_done;
            adc_done_s2 <= adc_done_s1;
            adc_data_s1 <= adc_data;
            adc_data_s2 <= adc_data_s1;
        end
    end

    // configuration registers
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            channel_enable_reg     <= `CAS_RESET_WORD;
            acquisition_config_reg <= `CAS_RESET_WORD;
        end else if (reg_wr) begin
            if (reg_addr == `CAS_ADDR_CHANNEL_ENABLE) begin
                channel_enable_reg <= reg_wdata;
            end
            if (reg_addr == `CAS_ADDR_ACQ_CONFIG) begin
                acquisition_config_reg <= reg_wdata;
            end
        end
    end

    // sequencer
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            state_reg <= cas_pkg::CAS_IDLE;
            chan_reg  <= 4'h0;
            pass_reg  <= 1'b0;
            ovs_reg   <= 8'h00;
            step_reg  <= 7'h00;
            tick_reg  <= 16'h0000;
            busy_reg  <= 1'b0;
        end else begin
            case (state_reg)
                cas_pkg::CAS_IDLE: begin
                    if (start_hit) begin
                        busy_reg  <= 1'b1;
                        chan_reg  <= 4'h0;
                        pass_reg  <= 1'b0;
                        ovs_reg   <= 8'h00;
                        state_reg <= cas_pkg::CAS_PICK;
                    end
                end
                cas_pkg::CAS_PICK: begin
                    if (!en_now) begin
                        state_reg <= cas_pkg::CAS_STORE;
                    end else if (chan_reg >= 4'd13) begin
                        step_reg  <= 7'h00;
                        tick_reg  <= 16'h0000;
                        state_reg <= cas_pkg::CAS_SETTLE;
                    end else begin
                        state_reg <= cas_pkg::CAS_REQ;
                    end
                end
                cas_pkg::CAS_SETTLE: begin
                    if (tick_reg == 16'(STEPS - 1)) begin
                        tick_reg <= 16'h0000;
                        if (step_reg == {1'b0, aux_steps}) begin
                            state_reg <= cas_pkg::CAS_REQ;
                        end else begin
                            step_reg <= step_reg + 7'h01;
                        end
                    end else begin
                        tick_reg <= tick_reg + 16'h0001;
                    end
                end
                cas_pkg::CAS_REQ: begin
                    state_reg <= cas_pkg::CAS_WAIT;
                end
                cas_pkg::CAS_WAIT: begin
                    if (adc_done_s2) begin
                        state_reg <= cas_pkg::CAS_STORE;
                    end
                end
                cas_pkg::CAS_STORE: begin
                    state_reg <= cas_pkg::CAS_PICK;
                    if (chan_reg < 4'd12) begin
                        chan_reg <= chan_reg + 4'h1;
                    end else if (chan_reg == 4'd12) begin
                        if (!pass_reg) begin
                            pass_reg <= 1'b1;
                            chan_reg <= 4'h0;
                        end else if (ovs_reg != 8'(OVS_CYCLES - 1)) begin
                            ovs_reg  <= ovs_reg + 8'h01;
                            pass_reg <= 1'b0;
                            chan_reg <= 4'h0;
                        end else begin
                            chan_reg <= 4'd13;
                            pass_reg <= 1'b0;
                        end
                    end else if (chan_reg == 4'd13) begin
                        chan_reg <= 4'd14;
                    end else begin
                        state_reg <= cas_pkg::CAS_FINISH;
                    end
                end
                cas_pkg::CAS_FINISH: begin
                    busy_reg  <= 1'b0;
                    state_reg <= cas_pkg::CAS_IDLE;
                end
                default: begin
                    state_reg <= cas_pkg::CAS_IDLE;
                end
            endcase
        end
    end

    // alu accumulators, one per averaged channel
    genvar gi;
    generate
        for (gi = 0; gi < 13; gi++) begin : g_acc
            always_ff @(posedge sys_clk or posedge rst) begin
                if (rst) begin
                    accum_reg[gi] <= 23'h000000;
                end else if (state_reg == cas_pkg::CAS_IDLE && start_hit) begin
                    accum_reg[gi] <= 23'h000000;
                end else if (state_reg == cas_pkg::CAS_WAIT && adc_done_s2 && chan_reg == 4'(gi)) begin
                    accum_reg[gi] <= accum_reg[gi] + {11'h000, adc_data_s2};
                end
            end
        end
    endgenerate

    // averaged, formatted result of one channel
    function automatic logic [15:0] cas_format(input logic [22:0] acc, input logic bip);
        logic [22:0] avg;
        logic [13:0] code;
        avg  = acc / 23'(2 * OVS_CYCLES);
        code = {avg[11:0], 2'b00};
        if (bip) begin
            code = code ^ 14'h2000;
        end
        return {code, 2'b00};
    endfunction : cas_format

    // result registers
    generate
        for (gi = 0; gi < 15; gi++) begin : g_res
            always_ff @(posedge sys_clk or posedge rst) begin
                if (rst) begin
                    result_reg[gi] <= `CAS_RESET_WORD;
                end else if (state_reg == cas_pkg::CAS_FINISH) begin
                    if (gi < 12 && !channel_enable_reg[gi]) begin
                        result_reg[gi] <= 16'h0000;
                    end else if (gi == 12 && !channel_enable_reg[`CAS_BIT_BLOCK_MEAS]) begin
                        result_reg[gi] <= 16'h0000;
                    end else if (gi < 13) begin
                        result_reg[gi] <= cas_format(accum_reg[gi < 13 ? gi : 0], bipolar);
                    end
                end else if (gi >= 13 && state_reg == cas_pkg::CAS_PICK && chan_reg == 4'(gi) && !en_now) begin
                    result_reg[gi] <= 16'h0000;
                end else if (gi >= 13 && state_reg == cas_pkg::CAS_WAIT && adc_done_s2 && chan_reg == 4'(gi)) begin
                    result_reg[gi] <= {4'h0, adc_data_s2};
                end
            end
        end
    endgenerate

    // done flag: set wins over a new start
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            scan_done_reg <= 1'b0;
        end else if (state_reg == cas_pkg::CAS_FINISH) begin
            scan_done_reg <= 1'b1;
        end else if (start_hit && state_reg == cas_pkg::CAS_IDLE) begin
            scan_done_reg <= 1'b0;
        end
    end

    // read port
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            rdata_reg <= 16'h0000;
        end else if (reg_rd) begin
            if (reg_addr == `CAS_ADDR_CHANNEL_ENABLE) begin
                rdata_reg <= channel_enable_reg;
            end else if (reg_addr == `CAS_ADDR_ACQ_CONFIG) begin
                rdata_reg <= acquisition_config_reg;
            end else if (reg_addr == `CAS_ADDR_SCAN_CTRL) begin
                rdata_reg <= {13'h0000, busy_reg, scan_done_reg, 1'b0};
            end else if (reg_addr >= `CAS_ADDR_CELL_BASE && reg_addr <= `CAS_ADDR_AUX_TWO) begin
                rdata_reg <= result_reg[4'(reg_addr - `CAS_ADDR_CELL_BASE)];
            end else if (reg_addr == `CAS_ADDR_ID_TWO) begin
                rdata_reg <= {CAL_CRC, 8'h00};
            end else if (reg_addr >= `CAS_ADDR_CAL_BASE && reg_addr < 6'h2C) begin
                rdata_reg <= CAL_INIT;
            end else begin
                rdata_reg <= 16'h0000;
            end
        end else begin
            rdata_reg <= 16'h0000;
        end
    end

    // analog outputs
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            thermistor_bias_output <= 1'b0;
        end else if (acquisition_config_reg[9]) begin
            thermistor_bias_output <= !acquisition_config_reg[8];
        end else begin
            thermistor_bias_output <= busy_reg && state_reg != cas_pkg::CAS_FINISH;
        end
    end

    assign reg_rdata             = rdata_reg;
    assign scan_done             = scan_done_reg;
    assign mux_select            = chan_reg;
    assign mux_invert            = pass_reg;
    assign adc_start             = state_reg == cas_pkg::CAS_REQ;
    assign use_bias_reference    = chan_reg >= 4'd13;
    assign block_divider_connect = channel_enable_reg[`CAS_BIT_BLOCK_CONNECT];
endmodule : cas_sequencer

// ---- cas_sequencer_properties.sv ----
// port checker of the acquisition sequencer with its bind
`include "cas_consts.svh"
module cas_sequencer_properties #(
    parameter int          OVS_CYCLES = 1,
    parameter logic [15:0] CAL_INIT   = 16'h0000,
    parameter logic [7:0]  CAL_CRC    = 8'h00
) (
    // clock, reset and register port
    input  wire logic        sys_clk,
    input  wire logic        rst,
    input  wire logic [5:0]  reg_addr,
    input  wire logic [15:0] reg_wdata,
    input  wire logic        reg_wr,
    input  wire logic        reg_rd,
    input  wire logic [15:0] reg_rdata,
    // adc side and analog controls
    input  wire logic [3:0]  mux_select,
    input  wire logic        mux_invert,
    input  wire logic        adc_start,
    input  wire logic        adc_done,
    input  wire logic [11:0] adc_data,
    input  wire logic        block_divider_connect,
    input  wire logic        thermistor_bias_output,
    input  wire logic        use_bias_reference,
    input  wire logic        scan_done
);
    logic [15:0] ce_reg, cfg_reg, snap_reg, gap_reg;
    logic [1:0]  hold_reg;
    logic        aux_reg;
    wire  logic  start_wr = reg_wr && reg_addr == `CAS_ADDR_SCAN_CTRL && reg_wdata[0];
    wire  logic [15:0] settle = (16'(cfg_reg[5:0]) + 16'h0001) * 16'h003C;
    // shadows of host writes, gap since the last conversion request or since use_bias_reference went high
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            {ce_reg, cfg_reg, snap_reg, gap_reg, hold_reg, aux_reg} <= '0;
        end else begin
            if (reg_wr && reg_addr == `CAS_ADDR_CHANNEL_ENABLE) ce_reg <= reg_wdata;
            if (reg_wr && reg_addr == `CAS_ADDR_ACQ_CONFIG) cfg_reg <= reg_wdata;
            hold_reg <= (reg_wr && reg_addr == `CAS_ADDR_ACQ_CONFIG) ? 2'h0 : hold_reg + 2'(hold_reg != 2'h3);
            if (start_wr) snap_reg <= ce_reg;
            gap_reg <= (adc_start || !use_bias_reference) ? 16'h0000 : gap_reg + 16'(gap_reg != 16'hFFFF);
            aux_reg <= start_wr ? 1'b0 : aux_reg | (adc_start && mux_select >= 4'hD);
        end
    end
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (rst);
    sequence cell_read;
        reg_rd && reg_addr >= `CAS_ADDR_CELL_BASE && reg_addr < `CAS_ADDR_BLOCK;
    endsequence
    sequence aux_request;
        adc_start && mux_select >= 4'hD;
    endsequence
    a_divider_follows_bit: assert property (block_divider_connect == ce_reg[15])
        else $error("divider connect differs from enable bit");
    a_cell_enable_gate: assert property (adc_start && mux_select < 4'hC |-> snap_reg[mux_select])
        else $error("disabled cell converted");
    a_block_enable_gate: assert property (adc_start && mux_select == 4'hC |-> snap_reg[14])
        else $error("block converted while not enabled");
    a_aux_bias_reference: assert property (aux_request |-> use_bias_reference && snap_reg[mux_select - 4'h1])
        else $error("aux conversion without enable or bias reference");
    a_aux_comes_last: assert property (adc_start && mux_select < 4'hD |-> !aux_reg)
        else $error("main conversion after aux conversion");
    a_aux_settle_time: assert property (aux_request |-> gap_reg >= settle && gap_reg <= settle + 16'h0028)
        else $error("aux settle time wrong");
    a_result_low_zero: assert property (cell_read |=> reg_rdata[1:0] == 2'h0)
        else $error("cell result low bits not zero");
    a_disabled_reads_zero: assert property (cell_read ##0 (scan_done && !snap_reg[reg_addr[3:0]]) |=> reg_rdata == 16'h0000)
        else $error("disabled cell result not zero");
    a_calibration_words: assert property (reg_rd && reg_addr >= `CAS_ADDR_CAL_BASE && reg_addr <= 6'h2B |=> reg_rdata == CAL_INIT)
        else $error("calibration word wrong");
    a_checksum_field: assert property (reg_rd && reg_addr == `CAS_ADDR_ID_TWO |=> reg_rdata[15:8] == CAL_CRC)
        else $error("checksum field wrong");
    a_bias_manual_mode: assert property (hold_reg == 2'h3 && cfg_reg[9] |-> thermistor_bias_output == !cfg_reg[8])
        else $error("manual bias level wrong");
    a_bias_auto_run: assert property (adc_start && hold_reg == 2'h3 && !cfg_reg[9] |-> thermistor_bias_output)
        else $error("auto bias off during acquisition");
    a_bias_auto_end: assert property (scan_done && $past(scan_done) && hold_reg == 2'h3 && !cfg_reg[9] |-> !thermistor_bias_output)
        else $error("auto bias on after acquisition");
endmodule : cas_sequencer_properties

bind cas_sequencer cas_sequencer_properties #(.OVS_CYCLES(OVS_CYCLES), .CAL_INIT(CAL_INIT), .CAL_CRC(CAL_CRC)) u_props (
    .sys_clk(sys_clk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .mux_select(mux_select), .mux_invert(mux_invert), .adc_start(adc_start),
    .adc_done(adc_done), .adc_data(adc_data), .block_divider_connect(block_divider_connect),
    .thermistor_bias_output(thermistor_bias_output), .use_bias_reference(use_bias_reference), .scan_done(scan_done));

// ---- cas_adc_model.sv ----
// behavioural multiplexer and adc partner, alternating fast and slow answers
module cas_adc_model (
    // clock
    input  wire logic        sys_clk,
    // sequencer side
    input  wire logic [3:0]  mux_select,
    input  wire logic        mux_invert,
    input  wire logic        adc_start,
    output logic             adc_done,
    output logic      [11:0] adc_data
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [11:0] val;
    int          cnt;
    initial begin
        adc_done = 1'b0;
        adc_data = 12'hFFF;
        cnt = 0;
        forever begin
            @(posedge sys_clk);
            if (adc_start === 1'b1) begin
                val = {mux_select, 8'h40} + (mux_invert ? 12'h002 : 12'h000);
                cnt++;
                repeat ((cnt % 2) ? 6 : 1) @(posedge sys_clk);
                adc_done <= 1'b1;
                adc_data <= val;
                repeat (3) @(posedge sys_clk);
                adc_done <= 1'b0;
                adc_data <= ~val;
            end
        end
    end
endmodule : cas_adc_model

// ---- cas_sequencer_tb.sv ----
// self-checking bench of the acquisition sequencer
`include "cas_consts.svh"
`define CHK(g, e) begin check_count++; if ((g) !== (e)) begin miscompares++; $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e); end end
module cas_sequencer_tb;
    timeunit 1ns;
    timeprecision 1ns;
    localparam logic [15:0] CAL_W = 16'h3C5A; // arbitrary
    localparam logic [7:0]  CRC_W = 8'h96;    // arbitrary
    logic        sys_clk, rst, reg_wr, reg_rd, adc_done, mux_invert, adc_start, bip;
    logic        block_divider_connect, thermistor_bias_output, use_bias_reference, scan_done;
    logic [5:0]  reg_addr;
    logic [15:0] reg_wdata, reg_rdata, q;
    logic [3:0]  mux_select;
    logic [11:0] adc_data;
    int          miscompares = 0, check_count = 0, cycles = 0;
    logic [15:0] ce_tab [4] = '{16'hD023, 16'h2800, 16'hF801, 16'h1FFF};
    logic [15:0] cfg_tab [4] = '{16'h1800, 16'h0602, 16'h0F01, 16'h013F};

    cas_sequencer #(.OVS_CYCLES(2), .CAL_INIT(CAL_W), .CAL_CRC(CRC_W)) dut (
        .sys_clk(sys_clk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
        .reg_rd(reg_rd), .reg_rdata(reg_rdata), .mux_select(mux_select), .mux_invert(mux_invert),
        .adc_start(adc_start), .adc_done(adc_done), .adc_data(adc_data),
        .block_divider_connect(block_divider_connect), .thermistor_bias_output(thermistor_bias_output),
        .use_bias_reference(use_bias_reference), .scan_done(scan_done));
    cas_adc_model u_adc (.sys_clk(sys_clk), .mux_select(mux_select), .mux_invert(mux_invert),
        .adc_start(adc_start), .adc_done(adc_done), .adc_data(adc_data));

    initial begin
        sys_clk = 1'b0;
        forever #50 sys_clk = ~sys_clk;
    end
    always @(posedge sys_clk) begin
        cycles++;
        if (cycles == 60000) begin
            miscompares++;
            report_and_stop();
        end
    end
    task automatic report_and_stop();
        if (miscompares == 0 && check_count > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask : report_and_stop
    task automatic wr(input logic [5:0] a, input logic [15:0] d);
        @(posedge sys_clk);
        reg_wr    <= 1'b1;
        reg_addr  <= a;
        reg_wdata <= d;
        @(posedge sys_clk);
        reg_wr    <= 1'b0;
    endtask : wr
    task automatic chk_rd(input logic [5:0] a, input logic [15:0] e);
        @(posedge sys_clk);
        reg_rd   <= 1'b1;
        reg_addr <= a;
        @(posedge sys_clk);
        reg_rd   <= 1'b0;
        @(negedge sys_clk);
        q = reg_rdata;
        `CHK(q, e)
    endtask : chk_rd
    function automatic logic [15:0] cell_exp(input logic [3:0] s, input logic b);
        return {s ^ {b, 3'h0}, 8'h41, 4'h0};
    endfunction : cell_exp

    initial begin
        rst = 1'b1;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        reg_addr = 6'h00;
        reg_wdata = 16'h0000;
        repeat (10) @(posedge sys_clk);
        rst <= 1'b0;
        chk_rd(`CAS_ADDR_CHANNEL_ENABLE, 16'h0000);
        chk_rd(`CAS_ADDR_ACQ_CONFIG, 16'h0000);
        for (int i = 0; i < 12; i++) chk_rd(`CAS_ADDR_CAL_BASE + 6'(i), CAL_W);
        chk_rd(`CAS_ADDR_ID_TWO, {CRC_W, 8'h00});
        wr(6'h3F, 16'hFFFF);
        chk_rd(6'h3F, 16'h0000);
        for (int t = 0; t < 4; t++) begin
            bip = cfg_tab[t][`CAS_BIT_DIAG_FORCE] ? cfg_tab[t][`CAS_BIT_DIAG_BIPOLAR] : cfg_tab[t][`CAS_BIT_POLARITY];
            wr(`CAS_ADDR_CHANNEL_ENABLE, ce_tab[t]);
            wr(`CAS_ADDR_ACQ_CONFIG, cfg_tab[t]);
            @(negedge sys_clk);
            `CHK(block_divider_connect, ce_tab[t][15])
            wr(`CAS_ADDR_SCAN_CTRL, 16'h0001);
            repeat (2) @(posedge sys_clk);
            for (int n = 0; n < 20000 && scan_done !== 1'b1; n++) @(posedge sys_clk);
            `CHK(scan_done, 1'b1)
            chk_rd(`CAS_ADDR_SCAN_CTRL, 16'h0002);
            for (int i = 0; i < 12; i++) chk_rd(`CAS_ADDR_CELL_BASE + 6'(i), ce_tab[t][i] ? cell_exp(4'(i), bip) : 16'h0000);
            chk_rd(`CAS_ADDR_BLOCK, ce_tab[t][14] ? cell_exp(4'hC, bip) : 16'h0000);
            chk_rd(`CAS_ADDR_AUX_ONE, ce_tab[t][12] ? 16'h0D40 : 16'h0000);
            chk_rd(`CAS_ADDR_AUX_TWO, ce_tab[t][13] ? 16'h0E40 : 16'h0000);
            `CHK(thermistor_bias_output, cfg_tab[t][9:8] == 2'b10)
        end
        report_and_stop();
    end
endmodule : cas_sequencer_tb
